// ### cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CSR_ADDR       = 8'h50;
   localparam logic [7:0] PIN_DIS_ADDR   = 8'h7F;
   localparam logic [7:0] IO_OFFSET      = 8'h20;
   localparam logic [7:0] IO_LIMIT       = 8'h40;
   localparam logic [7:0] CSR_RESET      = 8'h00;
   localparam logic [7:0] PIN_DIS_RESET  = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int POWER_OFF_BIT  = 7;
   localparam int BANDGAP_BIT    = 6;
   localparam int OUTPUT_BIT     = 5;
   localparam int FLAG_BIT       = 4;
   localparam int IRQ_EN_BIT     = 3;
   localparam int ROUTE_BIT      = 2;
   localparam int MODE_HI_BIT    = 1;
   localparam int MODE_LO_BIT    = 0;
   localparam int NEG_OFF_BIT    = 1;
   localparam int POS_OFF_BIT    = 0;
   localparam int SYNC_WIDTH     = 3;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      MODE_TOGGLE = 2'h0,
      MODE_RSVD   = 2'h1,
      MODE_FALL   = 2'h2,
      MODE_RISE   = 2'h3
   } irq_mode_t;

   typedef struct packed {
      logic      power_off;
      logic      bandgap;
      logic      irq_enable;
      logic      capture_route;
      irq_mode_t mode;
   } csr_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       io_space;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } reg_req_t;

endpackage : cmp_ctrl_pkg

// ### comparator_sync.sv
module comparator_sync #(
   parameter int W = 3
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   // ****************************************
   // Two-stage synchroniser per bit
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_reg;
         logic hold_reg;
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               meta_reg <= 1'b0;
               hold_reg <= 1'b0;
            end else begin
               meta_reg <= async_in[i];
               hold_reg <= meta_reg;
            end
         end
         assign sync_out[i] = hold_reg;
      end
   endgenerate

endmodule : comparator_sync

// ### analog_comparator_control.sv
// How it works
// - Power-off bit switches comparator off
// - Bandgap bit selects reference, else pin
// - Output bit is synchronised, one-two cycles
// - Selected output event sets the flag
// - Vectoring to handler clears the flag
// - Writing one clears flag, zero keeps
// - Request needs flag, enable, global enable
// - Route bit feeds output to capture
// - Route clear disconnects capture path
// - Mode: toggle, reserved, falling, rising
// - Pin disable bits gate buffers, read zero
// - Control register at 0x50, I/O 0x30
// - Output high when positive exceeds negative
// - Negative input mux from converter channels
module analog_comparator_control (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire cmp_ctrl_pkg::reg_req_t reg_req,
   output logic [7:0]                 rd_data,
   input  wire logic                  comparator_raw,
   input  wire logic                  positive_pin_level,
   input  wire logic                  negative_pin_level,
   input  wire logic                  global_irq_enable,
   input  wire logic                  irq_taken,
   input  wire logic                  negative_mux_enable,
   input  wire logic                  converter_enable,
   input  wire logic [2:0]            channel_select_low,
   output logic                       comparator_power_off,
   output logic                       bandgap_select,
   output logic                       neg_from_converter_pin,
   output logic [2:0]                 neg_channel,
   output logic                       comparator_output,
   output logic                       comparator_irq,
   output logic                       capture_route_enable,
   output logic                       capture_cmp_level,
   output logic                       positive_pin_digital_off,
   output logic                       negative_pin_digital_off,
   output logic                       positive_port_bit,
   output logic                       negative_port_bit
);

   // ****************************************
   // Address decode
   // ****************************************
   logic [7:0]              eff_addr;
   logic                    addr_ok;
   logic                    csr_hit;
   logic                    pin_hit;

   // I/O space only reaches the low 64 locations
   assign eff_addr = reg_req.io_space ? 8'(reg_req.addr + cmp_ctrl_pkg::IO_OFFSET)
                                      : reg_req.addr;
   assign addr_ok  = !reg_req.io_space || (reg_req.addr < cmp_ctrl_pkg::IO_LIMIT);
   assign csr_hit  = addr_ok && (eff_addr == cmp_ctrl_pkg::CSR_ADDR);
   assign pin_hit  = addr_ok && (eff_addr == cmp_ctrl_pkg::PIN_DIS_ADDR);

   // ****************************************
   // Synchronisers
   // ****************************************
   logic [cmp_ctrl_pkg::SYNC_WIDTH-1:0] sync_vec;

   comparator_sync #(
      .W        (cmp_ctrl_pkg::SYNC_WIDTH)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in ({negative_pin_level, positive_pin_level, comparator_raw}),
      .sync_out (sync_vec)
   );

   // ****************************************
   // Control register
   // ****************************************
   cmp_ctrl_pkg::csr_ctrl_t ctrl_reg;
   logic [7:0]              pin_dis_reg;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg <= cmp_ctrl_pkg::csr_ctrl_t'(6'h00);
      end else if (reg_req.wr && csr_hit) begin
         ctrl_reg.power_off     <= reg_req.wdata[cmp_ctrl_pkg::POWER_OFF_BIT];
         ctrl_reg.bandgap       <= reg_req.wdata[cmp_ctrl_pkg::BANDGAP_BIT];
         ctrl_reg.irq_enable    <= reg_req.wdata[cmp_ctrl_pkg::IRQ_EN_BIT];
         ctrl_reg.capture_route <= reg_req.wdata[cmp_ctrl_pkg::ROUTE_BIT];
         ctrl_reg.mode          <= cmp_ctrl_pkg::irq_mode_t'(
            reg_req.wdata[cmp_ctrl_pkg::MODE_HI_BIT:cmp_ctrl_pkg::MODE_LO_BIT]);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_dis_reg <= cmp_ctrl_pkg::PIN_DIS_RESET;
      end else if (reg_req.wr && pin_hit) begin
         pin_dis_reg <= {6'h00, reg_req.wdata[cmp_ctrl_pkg::NEG_OFF_BIT:cmp_ctrl_pkg::POS_OFF_BIT]};
      end
   end

   assign comparator_power_off     = ctrl_reg.power_off;
   assign bandgap_select           = ctrl_reg.bandgap;
   assign capture_route_enable     = ctrl_reg.capture_route;
   assign positive_pin_digital_off = pin_dis_reg[cmp_ctrl_pkg::POS_OFF_BIT];
   assign negative_pin_digital_off = pin_dis_reg[cmp_ctrl_pkg::NEG_OFF_BIT];

   // ****************************************
   // Negative input selection
   // ****************************************
   // Converter channels only borrowed while the converter is idle
   assign neg_from_converter_pin = negative_mux_enable && !converter_enable;
   assign neg_channel            = neg_from_converter_pin ? channel_select_low : 3'h0;

   // ****************************************
   // Comparator output and edge detect
   // ****************************************
   logic prev_reg;
   logic rise;
   logic fall;
   logic irq_event;

   // Analog result already high when positive beats negative; powered-off reads low
   assign comparator_output = sync_vec[0] && !ctrl_reg.power_off;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= comparator_output;
      end
   end

   assign rise = comparator_output && !prev_reg;
   assign fall = !comparator_output && prev_reg;

   always_comb begin
      case (ctrl_reg.mode)
         cmp_ctrl_pkg::MODE_TOGGLE: irq_event = rise || fall;
         cmp_ctrl_pkg::MODE_FALL:   irq_event = fall;
         cmp_ctrl_pkg::MODE_RISE:   irq_event = rise;
         default:                   irq_event = 1'b0;
      endcase
   end

   // ****************************************
   // Interrupt flag
   // ****************************************
   logic flag_reg;
   logic flag_clear;

   assign flag_clear = irq_taken
                    || (reg_req.wr && csr_hit && reg_req.wdata[cmp_ctrl_pkg::FLAG_BIT]);

   // A new event in the clearing cycle must not be lost
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flag_reg <= 1'b0;
      end else if (irq_event) begin
         flag_reg <= 1'b1;
      end else if (flag_clear) begin
         flag_reg <= 1'b0;
      end
   end

   assign comparator_irq = flag_reg && ctrl_reg.irq_enable && global_irq_enable;

   // ****************************************
   // Capture routing and port bits
   // ****************************************
   assign capture_cmp_level = ctrl_reg.capture_route && comparator_output;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         positive_port_bit <= 1'b0;
         negative_port_bit <= 1'b0;
      end else begin
         positive_port_bit <= sync_vec[1] && !positive_pin_digital_off;
         negative_port_bit <= sync_vec[2] && !negative_pin_digital_off;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (reg_req.rd && csr_hit) begin
         rd_data <= {ctrl_reg.power_off, ctrl_reg.bandgap, comparator_output, flag_reg,
                     ctrl_reg.irq_enable, ctrl_reg.capture_route, ctrl_reg.mode};
      end else if (reg_req.rd && pin_hit) begin
         rd_data <= pin_dis_reg;
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_power_off_write: assert property (
      @(posedge ref_clk) disable iff (rst)
      (reg_req.wr && csr_hit) |=> comparator_power_off == $past(reg_req.wdata[7]))
      else $error("power-off bit not taken from write");

   a_io_alias_write: assert property (
      @(posedge ref_clk) disable iff (rst)
      (reg_req.wr && reg_req.io_space && reg_req.addr == 8'h30)
         |=> bandgap_select == $past(reg_req.wdata[6]))
      else $error("I/O alias write missed control register");

   a_output_delay: assert property (
      @(posedge ref_clk) disable iff (rst)
      ##2 (comparator_output == ($past(comparator_raw, 2) && !ctrl_reg.power_off)))
      else $error("comparator output not two-stage synchronised");

   a_rise_sets_flag: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ctrl_reg.mode == cmp_ctrl_pkg::MODE_RISE && comparator_output && !prev_reg)
         |=> flag_reg)
      else $error("rising edge did not set flag");

   a_reserved_quiet: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ctrl_reg.mode == cmp_ctrl_pkg::MODE_RSVD && !flag_reg) |=> !flag_reg)
      else $error("reserved mode set the flag");

   a_vector_clears: assert property (
      @(posedge ref_clk) disable iff (rst)
      (irq_taken && !irq_event) |=> !flag_reg)
      else $error("flag survived interrupt vector");

   a_w1c_flag: assert property (
      @(posedge ref_clk) disable iff (rst)
      (reg_req.wr && csr_hit && !reg_req.wdata[4] && !irq_taken && flag_reg) |=> flag_reg)
      else $error("writing zero cleared the flag");

   a_irq_gating: assert property (
      @(posedge ref_clk) disable iff (rst)
      comparator_irq |-> (flag_reg && ctrl_reg.irq_enable && global_irq_enable))
      else $error("interrupt request without its conditions");

   a_irq_disable_write: assert property (
      @(posedge ref_clk) disable iff (rst)
      (reg_req.wr && csr_hit && !reg_req.wdata[cmp_ctrl_pkg::IRQ_EN_BIT]) |=> !comparator_irq)
      else $error("interrupt request after enable was cleared");

   a_capture_off: assert property (
      @(posedge ref_clk) disable iff (rst)
      !capture_route_enable |-> !capture_cmp_level)
      else $error("capture path live while route is off");

   a_pin_disable: assert property (
      @(posedge ref_clk) disable iff (rst)
      positive_pin_digital_off |=> !positive_port_bit)
      else $error("disabled pin read as one");

endmodule : analog_comparator_control

// ### analog_comparator_control_tb.sv
module analog_comparator_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Signals
   // ****************************************
   logic                   ref_clk, rst, raw, pos_pin, neg_pin, gie, taken, mux_en, conv_en;
   logic [2:0]             chan;
   cmp_ctrl_pkg::reg_req_t req;
   logic [7:0]             rd_data, d;
   logic                   pwr_off, bg, neg_conv, c_out, irq, route, cap, pos_off, neg_off;
   logic                   pos_bit, neg_bit;
   logic [2:0]             neg_ch;
   int                     err_count, compares;

   analog_comparator_control dut (.ref_clk(ref_clk), .rst(rst), .reg_req(req),
      .rd_data(rd_data), .comparator_raw(raw), .positive_pin_level(pos_pin),
      .negative_pin_level(neg_pin), .global_irq_enable(gie), .irq_taken(taken),
      .negative_mux_enable(mux_en), .converter_enable(conv_en), .channel_select_low(chan),
      .comparator_power_off(pwr_off), .bandgap_select(bg), .neg_from_converter_pin(neg_conv),
      .neg_channel(neg_ch), .comparator_output(c_out), .comparator_irq(irq),
      .capture_route_enable(route), .capture_cmp_level(cap),
      .positive_pin_digital_off(pos_off), .negative_pin_digital_off(neg_off),
      .positive_port_bit(pos_bit), .negative_port_bit(neg_bit));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Bus and compare helpers
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic access(input logic [7:0] a, input logic io, input logic w,
                         input logic [7:0] wd);
      @(posedge ref_clk) #1;
      req = '{addr: a, io_space: io, wr: w, rd: ~w, wdata: wd};
      @(posedge ref_clk) #1;
      req = '0;
      d = rd_data;
   endtask : access

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : wait_cyc

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_map;
      access(cmp_ctrl_pkg::CSR_ADDR, 1'b0, 1'b0, 8'h00);
      chk(d, cmp_ctrl_pkg::CSR_RESET);
      access(cmp_ctrl_pkg::PIN_DIS_ADDR, 1'b0, 1'b0, 8'h00);
      chk(d, cmp_ctrl_pkg::PIN_DIS_RESET);
      // Power-off and mode set first, then the interrupt enabled by the second write
      access(8'h30, 1'b1, 1'b1, 8'hE7);
      access(8'h30, 1'b1, 1'b1, 8'hEF);
      access(8'h50, 1'b0, 1'b0, 8'h00);
      chk(d, 8'hCF);
      chk({pwr_off, bg, route, c_out}, 8'h0E);
      access(8'h30, 1'b1, 1'b0, 8'h00);
      chk(d, 8'hCF);
      access(8'h51, 1'b0, 1'b1, 8'hFF);
      access(8'h51, 1'b0, 1'b0, 8'h00);
      chk(d, 8'h00);
      access(8'h50, 1'b0, 1'b1, 8'hC7);
      access(8'h50, 1'b0, 1'b1, 8'h00);
      access(8'h30, 1'b1, 1'b0, 8'h00);
      chk(d, 8'h00);
      $display("test reset_map done");
   endtask : t_reset_map

   task automatic t_modes;
      logic [7:0] er, ef;
      for (int m = 0; m < 4; m++) begin
         er = (m == 0 || m == 3) ? 8'h10 : 8'h00;
         ef = (m == 0 || m == 2) ? 8'h10 : 8'h00;
         access(8'h50, 1'b0, 1'b1, 8'h10 | 8'(m));
         raw = 1'b1;
         wait_cyc(1);
         chk({7'h0, c_out}, 8'h00);
         wait_cyc(3);
         chk({7'h0, c_out}, 8'h01);
         access(8'h50, 1'b0, 1'b0, 8'h00);
         chk(d & 8'h30, er | 8'h20);
         access(8'h50, 1'b0, 1'b1, 8'h10 | 8'(m));
         access(8'h50, 1'b0, 1'b0, 8'h00);
         chk(d & 8'h10, 8'h00);
         raw = 1'b0;
         wait_cyc(4);
         access(8'h50, 1'b0, 1'b0, 8'h00);
         chk(d & 8'h30, ef);
         access(8'h50, 1'b0, 1'b1, 8'h10 | 8'(m));
      end
      $display("test modes done");
   endtask : t_modes

   task automatic t_irq;
      access(8'h50, 1'b0, 1'b1, 8'h0B);
      gie = 1'b0;
      raw = 1'b1;
      wait_cyc(4);
      chk({7'h0, irq}, 8'h00);
      gie = 1'b1;
      wait_cyc(1);
      chk({7'h0, irq}, 8'h01);
      access(8'h50, 1'b0, 1'b1, 8'h03);
      chk({7'h0, irq}, 8'h00);
      access(8'h50, 1'b0, 1'b0, 8'h00);
      chk(d, 8'h33);
      access(8'h50, 1'b0, 1'b1, 8'h0B);
      taken = 1'b1;
      wait_cyc(1);
      taken = 1'b0;
      wait_cyc(1);
      chk({7'h0, irq}, 8'h00);
      raw = 1'b0;
      wait_cyc(4);
      $display("test irq done");
   endtask : t_irq

   task automatic t_route_pins;
      raw = 1'b1;
      wait_cyc(4);
      chk({7'h0, cap}, 8'h00);
      access(8'h50, 1'b0, 1'b1, 8'h03);
      access(8'h50, 1'b0, 1'b1, 8'h04);
      chk({6'h0, route, cap}, 8'h03);
      pos_pin = 1'b1;
      neg_pin = 1'b1;
      wait_cyc(4);
      chk({6'h0, neg_bit, pos_bit}, 8'h03);
      access(8'h7F, 1'b0, 1'b1, 8'hFE);
      wait_cyc(3);
      chk({6'h0, neg_bit, pos_bit}, 8'h01);
      chk({6'h0, neg_off, pos_off}, 8'h02);
      access(8'h7F, 1'b0, 1'b0, 8'h00);
      chk(d, 8'h02);
      mux_en = 1'b1;
      chan = 3'h5;
      wait_cyc(1);
      chk({4'h0, neg_conv, neg_ch}, 8'h0D);
      conv_en = 1'b1;
      wait_cyc(1);
      chk({4'h0, neg_conv, neg_ch}, 8'h00);
      $display("test route_pins done");
   endtask : t_route_pins

   // ****************************************
   // Verdict
   // ****************************************
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      {rst, raw, pos_pin, neg_pin, gie, taken, mux_en, conv_en} = 8'h80;
      chan = 3'h0;
      req = '0;
      err_count = 0;
      compares = 0;
      wait_cyc(8);
      rst = 1'b0;
      t_reset_map();
      t_modes();
      t_irq();
      t_route_pins();
      tally_and_finish();
   end

   initial begin
      #100us;
      err_count++;
      tally_and_finish();
   end
endmodule : analog_comparator_control_tb
